// [bench/wdt_core_tb.sv]
`timescale 1ns/100ps
`default_nettype none

module wdt_core_tb;

   // ----------------------------------------------------------------
   // stimulus, observed outputs and bookkeeping
   // ----------------------------------------------------------------
   logic pclk = 1'b0; // 125 MHz bus clock
   logic presetn = 1'b0; // power-on reset, low active
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic osc = 1'b0; // slow oscillator, ten pclk per period
   logic [7:0] boot = 8'hF0; // strap byte, mode field on top
   logic low_power = 1'b0;
   logic sys_reset_in = 1'b0;
   logic sys_reset_req;
   logic wdt_irq;
   logic wake_req;
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0; // cycle stamp for interval checks
   int osc_cnt = 0;
   int nwake = 0; // wake pulses seen
   int nrst = 0; // system reset pulses seen
   int t_wake = 0;
   int t_rst = 0;
   int t_grace = 0; // wake that opened the grace window
   int gap = 0; // cycles between the last two wakes
   int n0 = 0;
   int exp_cyc = 0;
   logic [7:0] lfsr = 8'h60; // seed 96
   logic [31:0] rd;
   logic err;
   logic [2:0] ps;
   logic [3:0] mode;

   wdt_core wdt_core_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .low_speed_internal_osc(osc), .boot_config_byte_four(boot),
      .low_power(low_power), .sys_reset_in(sys_reset_in), .sys_reset_req(sys_reset_req),
      .wdt_irq(wdt_irq), .wake_req(wake_req));

   // ----------------------------------------------------------------
   // clock, oscillator and pulse monitor
   // ----------------------------------------------------------------
   always #4 pclk = ~pclk;

   // oscillator derived from pclk, five cycles per phase
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      osc_cnt <= (osc_cnt == 9) ? 0 : osc_cnt + 1;
      osc <= (osc_cnt < 5);
   end

   // one-cycle pulses looked at mid-cycle, where they are settled
   always @(negedge pclk) begin
      if (wake_req === 1'b1) begin
         gap = cyc - t_wake;
         t_wake = cyc;
         nwake++;
      end
      if (sys_reset_req === 1'b1) begin
         t_rst = cyc;
         nrst++;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // next random byte
   function automatic logic [7:0] lfsr_next(input logic [7:0] x);
      return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
   endfunction

   // pclk cycles per interval: 64 ticks of ten pclk times the divider
   function automatic int exp_gap(input logic [2:0] s);
      return 640 * ((s == 3'h0) ? 1 : (4 << (s - 3'h1)));
   endfunction

   // compare and count
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // one apb transfer, held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // data and error taken at the edge that sees ready high
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // unlock then write the control register
   task automatic wctl(input logic [7:0] v);
      apb(1'b1, wdt_pkg::WDT_OFS_TA, {24'h0, wdt_pkg::WDT_TA_KEY1});
      apb(1'b1, wdt_pkg::WDT_OFS_TA, {24'h0, wdt_pkg::WDT_TA_KEY2});
      apb(1'b1, wdt_pkg::WDT_OFS_CTRL, {24'h0, v});
   endtask

   // read a register and compare
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask

   // power-on reset with a new mode field, random unused strap bits
   task automatic por(input logic [3:0] m);
      @(posedge pclk);
      presetn <= 1'b0;
      boot <= {m, lfsr[3:0]};
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      lfsr <= lfsr_next(lfsr);
      repeat (2) @(posedge pclk);
   endtask

   // wait for the next wake pulse, bounded
   task automatic wait_wake(input int lim);
      n0 = nwake;
      for (int k = 0; k < lim && nwake == n0; k++) @(posedge pclk);
   endtask

   // verdict
   task automatic end_sim();
      $display("mismatches %0d, comparisons %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      // reset values and access kinds, general purpose mode
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h07);
      rchk(wdt_pkg::WDT_OFS_CFG, 32'hF0);
      rchk(wdt_pkg::WDT_OFS_TA, 32'h0);
      apb(1'b1, 8'h10, {24'h0, lfsr}); // unmapped write, random data
      check({31'h0, err}, 32'h1);
      apb(1'b1, wdt_pkg::WDT_OFS_CTRL, 32'h80); // no unlock: dropped
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h07);
      n0 = nwake;
      repeat (800) @(posedge pclk);
      check(nwake, n0);
      apb(1'b1, wdt_pkg::WDT_OFS_IEN, 32'h3);
      // interval length per prescale code, the last one random
      for (int i = 0; i < 4; i++) begin
         ps = (i < 3) ? 3'(i) : {1'b0, lfsr[1:0]};
         exp_cyc = exp_gap(ps);
         wctl({5'h10, ps});
         wait_wake(2 * exp_cyc + 1000);
         rchk(wdt_pkg::WDT_OFS_CTRL, {24'h0, 5'h14, ps});
         check({31'h0, wdt_irq}, 32'h1);
         wctl({5'h10, ps});
         rchk(wdt_pkg::WDT_OFS_CTRL, {24'h0, 5'h10, ps});
         wait_wake(exp_cyc + 1000);
         check(gap, exp_cyc);
         check(nrst, 0);
      end
      // global enable off masks the raised flag
      apb(1'b1, wdt_pkg::WDT_OFS_IEN, 32'h1);
      repeat (2) @(negedge pclk);
      check({31'h0, wdt_irq}, 32'h0);
      // halted counter
      wctl(8'h00);
      n0 = nwake;
      repeat (3000) @(posedge pclk);
      check(nwake, n0);
      // low-power run bit off then on
      wctl(8'h80);
      low_power <= 1'b1;
      n0 = nwake;
      repeat (1500) @(posedge pclk);
      check(nwake, n0);
      wctl(8'h90);
      wait_wake(1500);
      check(nwake, n0 + 1);
      low_power <= 1'b0;
      // reset-timer mode: run bit has no effect, counts on its own
      por(4'h0);
      wctl(8'h80);
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h00);
      wait_wake(1500);
      check(nwake, n0 + 1);
      wctl(8'h40);
      repeat (30) @(posedge pclk);
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h00);
      wait_wake(1500);
      t_grace = t_wake;
      n0 = nrst;
      for (int k = 0; k < 6000 && nrst == n0; k++) @(posedge pclk);
      check(t_rst - t_grace, 5120);
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h08);
      @(posedge pclk);
      sys_reset_in <= 1'b1;
      @(posedge pclk);
      sys_reset_in <= 1'b0;
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h08);
      wctl(8'h00);
      rchk(wdt_pkg::WDT_OFS_CTRL, 32'h00);
      // low power stops reset-timer mode 0101, not mode 0011
      for (int j = 0; j < 2; j++) begin
         mode = (j == 0) ? wdt_pkg::WDT_CFG_STOP_LP : 4'h3;
         por(mode);
         rchk(wdt_pkg::WDT_OFS_CTRL, 32'h07);
         wctl(8'h00);
         low_power <= 1'b1;
         n0 = nwake;
         repeat (1500) @(posedge pclk);
         check({31'h0, nwake != n0}, 32'(j));
         low_power <= 1'b0;
      end
      end_sim();
   end

   // hang guard: the sequence needs under 60k cycles, allow 90k
   initial begin
      #720000;
      bad_count++;
      end_sim();
   end

endmodule

`default_nettype wire

// [core/wdt_core.sv]
`timescale 1ns/100ps
`default_nettype none

module wdt_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic low_speed_internal_osc,
   input wire logic [7:0] boot_config_byte_four,
   input wire logic low_power,
   input wire logic sys_reset_in,
   output logic sys_reset_req,
   output logic wdt_irq,
   output logic wake_req
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   wdt_pkg::wdt_state_t s_q; // registered state
   wdt_pkg::wdt_state_t d; // next state
   logic osc_tick; // one pclk per osc rising edge
   logic gp; // general purpose mode
   logic running; // counter allowed to advance
   logic ps_tick; // prescaler wraps
   logic tmo; // interval completed
   logic soft_rst; // any reset other than power-on
   logic access; // first access cycle
   logic commit; // transfer completes this edge
   logic wr_ctrl_ok; // unlocked control write
   logic [31:0] rdata; // read mux

   // ----------------------------------------------------------------
   // oscillator tick
   // ----------------------------------------------------------------
   // slow clock is sampled and edge detected on pclk
   wdt_osc_tick wdt_osc_tick_i (
      .pclk(pclk),
      .presetn(presetn),
      .osc_in(low_speed_internal_osc),
      .tick(osc_tick)
   );

   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   // mode, run gating, ticks and bus phases
   always_comb begin
      gp = (s_q.cfg == wdt_pkg::WDT_CFG_GP);
      if (!s_q.cfg_ok) begin
         running = 1'b0;
      end else if (gp) begin
         running = s_q.run && (!low_power || s_q.lp_run);
      end else begin
         running = !(s_q.cfg == wdt_pkg::WDT_CFG_STOP_LP && low_power);
      end
      // at or past the last count, so a smaller ratio written mid-count
      // takes effect on the next tick instead of after a full wrap
      ps_tick = osc_tick && running
         && (s_q.pre >= wdt_pkg::wdt_div_last(s_q.ps));
      tmo = ps_tick && (s_q.cnt == wdt_pkg::WDT_CNT_LAST);
      soft_rst = sys_reset_in || s_q.sysrst;
      access = psel && penable && !s_q.pready;
      commit = psel && penable && s_q.pready;
      wr_ctrl_ok = commit && pwrite && (paddr == wdt_pkg::WDT_OFS_CTRL)
         && (s_q.ta == wdt_pkg::WDT_TA_OPEN);
   end

   // ----------------------------------------------------------------
   // read mux
   // ----------------------------------------------------------------
   // upper bits read as zero
   always_comb begin
      rdata = 32'h0000_0000;
      case (paddr)
         wdt_pkg::WDT_OFS_CTRL: begin
            rdata[wdt_pkg::WDT_BIT_RUN] = s_q.run;
            rdata[wdt_pkg::WDT_BIT_CLR] = s_q.clr_pend;
            rdata[wdt_pkg::WDT_BIT_TOF] = s_q.tof;
            rdata[wdt_pkg::WDT_BIT_LPRUN] = s_q.lp_run;
            rdata[wdt_pkg::WDT_BIT_RSTF] = s_q.rst_flag;
            rdata[2:0] = s_q.ps;
         end
         wdt_pkg::WDT_OFS_IEN: begin
            rdata[wdt_pkg::WDT_BIT_IEN] = s_q.ien;
            rdata[wdt_pkg::WDT_BIT_EA] = s_q.ea;
         end
         wdt_pkg::WDT_OFS_CFG: begin
            rdata[wdt_pkg::WDT_CFG_LSB +: 4] = s_q.cfg;
         end
         default: begin
            rdata = 32'h0000_0000;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      d = s_q;
      d.pready = access; // one wait cycle, then ready
      d.pslverr = 1'b0;
      d.sysrst = 1'b0;
      d.wake = 1'b0;
      d.lp_q = low_power;
      // read data and error ride with ready
      if (access) begin
         d.prdata = pwrite ? 32'h0000_0000 : rdata;
         d.pslverr = (paddr != wdt_pkg::WDT_OFS_CTRL) && (paddr != wdt_pkg::WDT_OFS_TA)
            && (paddr != wdt_pkg::WDT_OFS_IEN) && (paddr != wdt_pkg::WDT_OFS_CFG);
      end
      // catch the boot mode field after reset release
      if (!s_q.cfg_ok) begin
         d.cfg = boot_config_byte_four[wdt_pkg::WDT_CFG_LSB +: 4];
         d.cfg_ok = 1'b1;
      end
      // prescaler and interval counter
      if (osc_tick && running) begin
         if (ps_tick) begin
            d.pre = 8'h00;
            d.cnt = s_q.cnt + 6'h01; // wraps, keeps counting
         end else begin
            d.pre = s_q.pre + 8'h01;
         end
      end
      // grace window in reset timer mode
      if (s_q.grace_on && osc_tick) begin
         if (s_q.grace == wdt_pkg::WDT_GRACE_LAST) begin
            d.sysrst = 1'b1;
            d.grace_on = 1'b0;
         end else begin
            d.grace = s_q.grace + 9'h001;
         end
      end
      // interval done: wake, and in reset mode open grace
      if (tmo) begin
         d.wake = 1'b1;
         if (!gp && !s_q.grace_on) begin
            d.grace_on = 1'b1;
            d.grace = 9'h000;
         end
      end
      // pending clear completes on the next osc clock
      if (s_q.clr_pend && osc_tick) begin
         d.cnt = 6'h00;
         d.pre = 8'h00;
         d.grace_on = 1'b0;
         d.grace = 9'h000;
         d.clr_pend = 1'b0;
         d.sysrst = 1'b0;
      end
      // low power entry or exit restarts the interval
      if (low_power != s_q.lp_q) begin
         d.cnt = 6'h00;
         d.pre = 8'h00;
      end
      // register writes
      if (commit && pwrite) begin
         if (paddr == wdt_pkg::WDT_OFS_TA) begin
            if (pwdata[7:0] == wdt_pkg::WDT_TA_KEY1) begin
               d.ta = wdt_pkg::WDT_TA_HALF;
            end else if (pwdata[7:0] == wdt_pkg::WDT_TA_KEY2
               && s_q.ta == wdt_pkg::WDT_TA_HALF) begin
               d.ta = wdt_pkg::WDT_TA_OPEN;
            end else begin
               d.ta = wdt_pkg::WDT_TA_LOCKED;
            end
         end else begin
            d.ta = wdt_pkg::WDT_TA_LOCKED; // one write per unlock
         end
         if (wr_ctrl_ok) begin
            if (gp) begin
               d.run = pwdata[wdt_pkg::WDT_BIT_RUN];
               d.lp_run = pwdata[wdt_pkg::WDT_BIT_LPRUN];
            end
            if (pwdata[wdt_pkg::WDT_BIT_CLR]) begin
               d.clr_pend = 1'b1;
            end
            d.tof = pwdata[wdt_pkg::WDT_BIT_TOF];
            d.rst_flag = pwdata[wdt_pkg::WDT_BIT_RSTF];
            d.ps = pwdata[2:0];
         end
         if (paddr == wdt_pkg::WDT_OFS_IEN) begin
            d.ien = pwdata[wdt_pkg::WDT_BIT_IEN];
            d.ea = pwdata[wdt_pkg::WDT_BIT_EA];
         end
      end
      // hardware sets win over software clears
      if (tmo) begin
         d.tof = 1'b1;
      end
      if (s_q.sysrst) begin
         d.rst_flag = 1'b1;
      end
      // non power-on reset: keep prescale select and reset flag
      if (soft_rst) begin
         d.cnt = 6'h00;
         d.pre = 8'h00;
         d.grace_on = 1'b0;
         d.grace = 9'h000;
         d.clr_pend = 1'b0;
         d.tof = 1'b0;
         d.run = 1'b0;
         d.lp_run = 1'b0;
         d.ien = 1'b0;
         d.ea = 1'b0;
         d.ta = wdt_pkg::WDT_TA_LOCKED;
         d.cfg_ok = 1'b0;
         d.wake = 1'b0;
      end
      d.irq = d.tof && d.ien && d.ea;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // presetn is the power-on reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= wdt_pkg::WDT_STATE_RST;
      end else begin
         s_q <= d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign prdata = s_q.prdata;
   assign pready = s_q.pready;
   assign pslverr = s_q.pslverr;
   assign sys_reset_req = s_q.sysrst;
   assign wdt_irq = s_q.irq;
   assign wake_req = s_q.wake;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // grace counter at its end without a clear
   sequence s_grace_end;
      s_q.grace_on && osc_tick && s_q.grace == 9'h1FF && !(s_q.clr_pend) && !soft_rst;
   endsequence

   // locked control write arriving
   sequence s_locked_ctrl_write;
      commit && pwrite && paddr == 8'h00 && s_q.ta != wdt_pkg::WDT_TA_OPEN && !soft_rst;
   endsequence

   // clear request written through the unlock
   sequence s_clear_write;
      wr_ctrl_ok && pwdata[wdt_pkg::WDT_BIT_CLR] && !soft_rst;
   endsequence

   // irq only with flag and both enables
   chk_irq_gate: assert property (wdt_irq |-> s_q.tof && s_q.ien && s_q.ea)
      else $error("irq without flag and both enables");
   // global enable low keeps irq low
   chk_irq_mask: assert property (!s_q.ea && !(commit && pwrite
      && paddr == wdt_pkg::WDT_OFS_IEN) |=> !wdt_irq)
      else $error("irq raised with global enable low");
   // grace end without clear gives reset, then the reset flag
   chk_grace_reset: assert property (s_grace_end |=> sys_reset_req ##1 s_q.rst_flag)
      else $error("no reset after grace window");
   // pending clear closes the grace window
   chk_grace_cancel: assert property (s_q.clr_pend && osc_tick && !soft_rst
      |=> !s_q.grace_on)
      else $error("pending clear left grace window open");
   // general purpose mode never resets the system
   chk_gp_no_reset: assert property (s_q.cfg_ok && gp && !s_q.grace_on |=> !sys_reset_req)
      else $error("reset raised in general purpose mode");
   // locked control write leaves the prescale select alone
   chk_ta_guard: assert property (s_locked_ctrl_write |=> $stable(s_q.ps))
      else $error("locked write changed prescale");
   // other resets keep the prescale select
   chk_ps_keep: assert property (sys_reset_in && !commit |=> $stable(s_q.ps))
      else $error("prescale changed on non power-on reset");
   // mode field latched one edge after any reset
   chk_cfg_latch: assert property (presetn && !s_q.cfg_ok && !soft_rst |=> s_q.cfg_ok)
      else $error("mode field not latched after reset");
   // other resets keep the reset flag
   chk_rstf_keep: assert property (sys_reset_in && !s_q.sysrst && !wr_ctrl_ok
      |=> $stable(s_q.rst_flag))
      else $error("reset flag changed on other reset");
   // reset timer mode ignores run and low power run writes
   chk_rt_run_lock: assert property (s_q.cfg_ok && !gp && !soft_rst
      |=> $stable(s_q.run) && $stable(s_q.lp_run))
      else $error("run bits changed in reset timer mode");
   // unlocked clear write raises the pending bit
   chk_clr_request: assert property (s_clear_write |=> s_q.clr_pend)
      else $error("clear request not pending");
   // pending clear completes on the osc tick
   chk_clear_done: assert property (s_q.clr_pend && osc_tick && !soft_rst && !wr_ctrl_ok
      |=> !s_q.clr_pend && s_q.cnt == 6'h00)
      else $error("clear did not complete on osc tick");
   // time-out sets the flag and wakes
   chk_timeout_flag: assert property (tmo && !soft_rst |=> s_q.tof && wake_req)
      else $error("time-out did not set flag and wake");
   // wake is a single cycle pulse
   chk_wake_pulse: assert property (wake_req |=> !wake_req)
      else $error("wake pulse longer than one cycle");
   // halted gp counter holds its count
   chk_gp_halt: assert property (s_q.cfg_ok && gp && !s_q.run && !s_q.clr_pend
      && low_power == s_q.lp_q && !soft_rst |=> $stable(s_q.cnt))
      else $error("gp counter moved while halted");
   // low power entry or exit restarts the interval
   chk_lp_clear: assert property (low_power != s_q.lp_q |=> s_q.cnt == 6'h00
      && s_q.pre == 8'h00)
      else $error("low power change left counter set");
   // mode 0101 stands still in low power
   chk_mode5_stop: assert property (s_q.cfg_ok && s_q.cfg == 4'h5 && low_power
      && s_q.lp_q && !s_q.clr_pend && !soft_rst |=> $stable(s_q.cnt))
      else $error("mode 5 counted in low power");
   // one wait state, then a single ready cycle
   chk_apb_ready: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready not a single cycle after one wait");

endmodule
`default_nettype wire

// [core/wdt_osc_tick.sv]
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// slow oscillator edge to one-cycle tick on pclk
// ----------------------------------------------------------------
module wdt_osc_tick (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic osc_in,
   output logic tick
);

   // sync pair, edge history and tick register
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic tick;
   } wdt_tick_state_t;

   wdt_tick_state_t t_q; // registered state
   wdt_tick_state_t t_d; // next state

   // s1 feeds only s2; edge seen on the settled copy
   always_comb begin
      t_d = t_q;
      t_d.s1 = osc_in;
      t_d.s2 = t_q.s1;
      t_d.s3 = t_q.s2;
      t_d.tick = t_q.s2 & ~t_q.s3;
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         t_q <= '0;
      end else begin
         t_q <= t_d;
      end
   end

   assign tick = t_q.tick;

endmodule
`default_nettype wire

// [core/wdt_pkg.sv]
`default_nettype none

package wdt_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses on the apb bus)
   // ----------------------------------------------------------------
   localparam logic [7:0] WDT_OFS_CTRL = 8'h00; // watchdog_control_register
   localparam logic [7:0] WDT_OFS_TA = 8'h04; // timed_access_register
   localparam logic [7:0] WDT_OFS_IEN = 8'h08; // irq enable bits
   localparam logic [7:0] WDT_OFS_CFG = 8'h0C; // boot configuration, read only

   // ----------------------------------------------------------------
   // control register field positions
   // ----------------------------------------------------------------
   localparam int WDT_BIT_RUN = 7; // gp_timer_run_bit
   localparam int WDT_BIT_CLR = 6; // counter_clear_bit
   localparam int WDT_BIT_TOF = 5; // timeout_flag
   localparam int WDT_BIT_LPRUN = 4; // run_in_low_power_bit
   localparam int WDT_BIT_RSTF = 3; // watchdog_reset_flag
   localparam int WDT_BIT_IEN = 0; // watchdog_irq_enable in irq enable reg
   localparam int WDT_BIT_EA = 1; // global_irq_enable in irq enable reg
   localparam int WDT_CFG_LSB = 4; // wd_config_mode_field in boot byte

   // ----------------------------------------------------------------
   // reset values, mode codes, keys and counts
   // ----------------------------------------------------------------
   localparam logic [2:0] WDT_PS_RST = 3'h7; // longest interval after power-on
   localparam logic [3:0] WDT_CFG_RST = 4'hF; // mode field before strap load
   localparam logic [3:0] WDT_CFG_GP = 4'hF; // general purpose timer mode
   localparam logic [3:0] WDT_CFG_STOP_LP = 4'h5; // reset timer, stops in low power
   localparam logic [7:0] WDT_TA_KEY1 = 8'hAA; // first unlock byte
   localparam logic [7:0] WDT_TA_KEY2 = 8'h55; // second unlock byte
   localparam logic [5:0] WDT_CNT_LAST = 6'h3F; // 64 prescaled ticks per interval
   localparam logic [8:0] WDT_GRACE_LAST = 9'h1FF; // 512 osc clocks of grace

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   // timed access unlock progress
   typedef enum logic [1:0] {
      WDT_TA_LOCKED = 2'b00,
      WDT_TA_HALF = 2'b01,
      WDT_TA_OPEN = 2'b10
   } wdt_ta_t;

   // whole state of the watchdog core except the oscillator tick registers
   typedef struct packed {
      logic [3:0] cfg; // latched mode field
      logic cfg_ok; // mode field loaded since reset
      logic run; // gp run bit
      logic clr_pend; // counter clear in progress
      logic tof; // time-out flag
      logic lp_run; // gp keeps running in low power
      logic rst_flag; // a watchdog reset happened since power-on or last clear
      logic [2:0] ps; // interval prescale select
      logic ien; // watchdog irq enable
      logic ea; // global irq enable
      wdt_ta_t ta; // unlock state
      logic [7:0] pre; // prescaler
      logic [5:0] cnt; // interval counter
      logic grace_on; // grace window running
      logic [8:0] grace; // grace counter
      logic lp_q; // previous low power level
      logic sysrst; // system reset request
      logic irq; // irq request
      logic wake; // wake pulse
      logic pready; // apb ready
      logic pslverr; // apb error
      logic [31:0] prdata; // apb read data
   } wdt_state_t;

   localparam wdt_state_t WDT_STATE_RST = '{cfg: WDT_CFG_RST, ps: WDT_PS_RST,
      ta: WDT_TA_LOCKED, default: '0};

   // last prescaler count for each divide ratio 1,4,8 .. 256
   function automatic logic [7:0] wdt_div_last(input logic [2:0] sel);
      logic [7:0] r;
      case (sel)
         3'h0: r = 8'h00;
         3'h1: r = 8'h03;
         3'h2: r = 8'h07;
         3'h3: r = 8'h0F;
         3'h4: r = 8'h1F;
         3'h5: r = 8'h3F;
         3'h6: r = 8'h7F;
         default: r = 8'hFF;
      endcase
      return r;
   endfunction

endpackage
`default_nettype wire
